// ### verilog/fpc_pkg.sv
// Constants and types shared by the fault pin protocol control block
package fpc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_PROTO  = 8'h00;
   localparam logic [7:0] OFS_RECOV  = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_ALARM  = 8'h0c;
   localparam logic [7:0] OFS_IRQST  = 8'h10;
   localparam logic [7:0] OFS_IRQMSK = 8'h14;

   // Protocol register fields
   localparam int MODE_LSB = 0;
   localparam int FIRST_PRESCALER_LSB = 4;
   localparam int SECOND_PRESCALER_LSB = 12;
   localparam int FSHT_LSB = 20;
   localparam int TW       = 8;

   // Recovery register fields
   localparam int RD_LSB    = 0;
   localparam int START0    = 8;
   localparam int START1    = 9;
   localparam int LEAVE_BIT = 10;

   // Status register fields
   localparam int ST_FAULT = 0;
   localparam int ST_FSTF  = 1;
   localparam int ST_RT0   = 2;
   localparam int ST_RT1   = 3;
   localparam int ST_PIN   = 4;

   // Alarm register: group six bit 7, group ten bits 16, 17, 21
   localparam int ALARM_GROUP_SIX_7   = 0;
   localparam int ALARM_GROUP_TEN_16 = 1;
   localparam int ALARM_GROUP_TEN_17 = 2;
   localparam int ALARM_GROUP_TEN_21 = 3;

   // Interrupt events
   localparam int EV_ALARM = 0;
   localparam int EV_FAULT = 1;
   localparam int EV_FSTF  = 2;
   localparam int EV_RTEXP = 3;
   localparam int NEV      = 4;

   // Reset values, plus the fault-state pin pattern
   localparam logic [31:0] PROTO_RST  = 32'h0000_0000;
   localparam logic [7:0]  RD_RST     = 8'h00;
   localparam logic [3:0]  IRQMSK_RST = 4'h0;
   localparam logic [1:0]  PIN_FREE   = 2'b01;
   localparam logic [1:0]  PIN_FAULT  = 2'b00;

   typedef enum logic [1:0] {
      MODE_BISTABLE = 2'b00,
      MODE_DUALRAIL = 2'b01,
      MODE_TIMESW   = 2'b10
   } fpc_mode_t;

   typedef enum logic [1:0] {
      ST_FREE  = 2'b01,
      ST_FLT   = 2'b10
   } fpc_state_t;
endpackage

// ### verilog/fpc_tick_div.sv
// Reloading down counter giving a one-cycle tick every reload+1 enables
`timescale 1ns/1ps
module fpc_tick_div (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       en,
   input  wire logic [7:0] reload,
   output logic            tick
);
   logic [7:0] cnt_q;

   // Reload is read only at the wrap, so a new value never cuts a period short
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 8'h00;
      end else if (en) begin
         if (cnt_q == 8'h00) begin
            cnt_q <= reload;
         end else begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end

   assign tick = en && (cnt_q == 8'h00);
endmodule

// ### verilog/fpc_fault_pin_ctrl.sv
// Fault pin protocol control: APB registers, pin protocols, timers, alarms
// What this block does
// - Mode field 00 bistable, 01 dual-rail, 10 time-switching selects the pin protocol.
// - Time-switching toggles pin 0; dual-rail toggles both pins together each period.
// - In fault state the time flag stays 0 until minimum duration elapses.
// - Second prescaler change while toggling raises group six/ten alarms; reset-only clear.
// - First prescaler or high-time change in early fault state raises same alarms.
// - First prescaler or recovery delay change with running timer raises group ten alarm.
// - Each recovery timer shows its own running bit in the status register.
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module fpc_fault_pin_ctrl (
   input  wire logic        CLK_SYS,
   input  wire logic        RSTN,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        FAULT_REQ,
   output logic [1:0]       FAULT_PIN,
   output logic             IRQ
);
   localparam int TW = fpc_pkg::TW;

   logic [31:0]            proto_q;
   logic [TW-1:0]          rd_q;
   logic [3:0]             alarm_q;
   logic [3:0]             irq_st_q;
   logic [3:0]             irq_msk_q;
   logic [31:0]            prdata_q;
   logic                   slverr_q;
   fpc_pkg::fpc_state_t    st_q;
   logic                   fstf_q;
   logic [TW-1:0]          fs_cnt_q;
   logic [TW-1:0]          rt0_cnt_q;
   logic [TW-1:0]          rt1_cnt_q;
   logic                   rt0_q;
   logic                   rt1_q;
   logic [1:0]             pin_q;

   logic                   setup;
   logic                   access;
   logic                   mapped;
   logic                   wr_proto;
   logic                   wr_recov;
   logic                   rd_irqst;
   fpc_pkg::fpc_mode_t     mode;
   logic [TW-1:0]          first_prescaler;
   logic [TW-1:0]          second_prescaler;
   logic [TW-1:0]          fsht;
   logic                   toggling;
   logic                   in_fault;
   logic                   first_prescaler_chg;
   logic                   second_prescaler_chg;
   logic                   fsht_chg;
   logic                   rd_chg;
   logic                   tick1;
   logic                   tick2;
   logic                   rt0_exp;
   logic                   rt1_exp;
   logic                   enter_fault;
   logic                   leave_fault;
   logic                   fstf_set;
   logic [3:0]             alarm_set;
   logic [3:0]             events;
   logic [31:0]            rdata;

   // APB decode; zero wait states
   assign setup    = PSEL && !PENABLE;
   assign access   = PSEL && PENABLE;
   assign mapped   = (PADDR == fpc_pkg::OFS_PROTO) || (PADDR == fpc_pkg::OFS_RECOV)
                  || (PADDR == fpc_pkg::OFS_STATUS) || (PADDR == fpc_pkg::OFS_ALARM)
                  || (PADDR == fpc_pkg::OFS_IRQST) || (PADDR == fpc_pkg::OFS_IRQMSK);
   assign wr_proto = access && PWRITE && (PADDR == fpc_pkg::OFS_PROTO);
   assign wr_recov = access && PWRITE && (PADDR == fpc_pkg::OFS_RECOV);
   assign rd_irqst = access && !PWRITE && (PADDR == fpc_pkg::OFS_IRQST);
   assign PREADY   = 1'b1;
   assign PRDATA   = prdata_q;
   assign PSLVERR  = slverr_q && access;

   // Field views of the live configuration
   assign first_prescaler = proto_q[fpc_pkg::FIRST_PRESCALER_LSB +: TW];
   assign second_prescaler = proto_q[fpc_pkg::SECOND_PRESCALER_LSB +: TW];
   assign fsht = proto_q[fpc_pkg::FSHT_LSB +: TW];
   assign in_fault = (st_q == fpc_pkg::ST_FLT);

   // Code 11 is undefined and falls back to the static protocol
   always_comb begin
      unique case (proto_q[fpc_pkg::MODE_LSB +: 2])
         2'b01:   mode = fpc_pkg::MODE_DUALRAIL;
         2'b10:   mode = fpc_pkg::MODE_TIMESW;
         default: mode = fpc_pkg::MODE_BISTABLE;
      endcase
   end

   assign toggling = (mode != fpc_pkg::MODE_BISTABLE);

   // Field changes carried by a protocol or recovery write
   assign first_prescaler_chg = wr_proto && (PWDATA[fpc_pkg::FIRST_PRESCALER_LSB +: TW] != first_prescaler);
   assign second_prescaler_chg = wr_proto && (PWDATA[fpc_pkg::SECOND_PRESCALER_LSB +: TW] != second_prescaler);
   assign fsht_chg = wr_proto && (PWDATA[fpc_pkg::FSHT_LSB +: TW] != fsht);
   assign rd_chg   = wr_recov && (PWDATA[fpc_pkg::RD_LSB +: TW] != rd_q);

   // Time base: first prescaler divides the clock, second divides that tick
   fpc_tick_div u_div1 (
      .clk    (CLK_SYS),
      .rst_n  (RSTN),
      .en     (1'b1),
      .reload (first_prescaler),
      .tick   (tick1)
   );

   fpc_tick_div u_div2 (
      .clk    (CLK_SYS),
      .rst_n  (RSTN),
      .en     (tick1),
      .reload (second_prescaler),
      .tick   (tick2)
   );

   // Configuration registers
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         proto_q   <= fpc_pkg::PROTO_RST;
         rd_q      <= fpc_pkg::RD_RST;
         irq_msk_q <= fpc_pkg::IRQMSK_RST;
      end else begin
         if (wr_proto) begin
            proto_q <= {4'h0, PWDATA[27:4], 2'b00, PWDATA[1:0]};
         end
         if (wr_recov) begin
            rd_q <= PWDATA[fpc_pkg::RD_LSB +: TW];
         end
         if (access && PWRITE && (PADDR == fpc_pkg::OFS_IRQMSK)) begin
            irq_msk_q <= PWDATA[3:0];
         end
      end
   end

   // Fault state machine
   assign rt0_exp     = rt0_q && tick1 && (rt0_cnt_q >= rd_q);
   assign rt1_exp     = rt1_q && tick1 && (rt1_cnt_q >= rd_q);
   assign enter_fault = !in_fault && (FAULT_REQ || rt0_exp || rt1_exp);
   assign leave_fault = in_fault && fstf_q && wr_recov && PWDATA[fpc_pkg::LEAVE_BIT];

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         st_q <= fpc_pkg::ST_FREE;
      end else begin
         unique case (st_q)
            fpc_pkg::ST_FREE: begin
               if (enter_fault) begin
                  st_q <= fpc_pkg::ST_FLT;
               end
            end
            fpc_pkg::ST_FLT: begin
               if (leave_fault) begin
                  st_q <= fpc_pkg::ST_FREE;
               end
            end
            default: st_q <= fpc_pkg::ST_FREE;
         endcase
      end
   end

   // Minimum fault-state duration in first-prescaler ticks
   assign fstf_set = in_fault && !fstf_q && (fs_cnt_q >= fsht);

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         fs_cnt_q <= '0;
         fstf_q   <= 1'b0;
      end else if (!in_fault) begin
         fs_cnt_q <= '0;
         fstf_q   <= 1'b0;
      end else begin
         if (tick1 && (fs_cnt_q < fsht)) begin
            fs_cnt_q <= fs_cnt_q + 8'h01;
         end
         if (fstf_set) begin
            fstf_q <= 1'b1;
         end
      end
   end

   // Recovery timers, started by software, expire into the fault state
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         rt0_q     <= 1'b0;
         rt0_cnt_q <= '0;
      end else if (wr_recov && PWDATA[fpc_pkg::START0] && !rt0_q) begin
         rt0_q     <= 1'b1;
         rt0_cnt_q <= '0;
      end else if (rt0_exp) begin
         rt0_q     <= 1'b0;
      end else if (rt0_q && tick1) begin
         rt0_cnt_q <= rt0_cnt_q + 8'h01;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         rt1_q     <= 1'b0;
         rt1_cnt_q <= '0;
      end else if (wr_recov && PWDATA[fpc_pkg::START1] && !rt1_q) begin
         rt1_q     <= 1'b1;
         rt1_cnt_q <= '0;
      end else if (rt1_exp) begin
         rt1_q     <= 1'b0;
      end else if (rt1_q && tick1) begin
         rt1_cnt_q <= rt1_cnt_q + 8'h01;
      end
   end

   // Fault pins; toggles step only on the second-prescaler tick
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         pin_q <= fpc_pkg::PIN_FREE;
      end else if (in_fault) begin
         pin_q <= fpc_pkg::PIN_FAULT;
      end else begin
         unique case (mode)
            fpc_pkg::MODE_TIMESW: begin
               pin_q[1] <= 1'b0;
               if (tick2) begin
                  pin_q[0] <= !pin_q[0];
               end
            end
            fpc_pkg::MODE_DUALRAIL: begin
               if (pin_q[1] == pin_q[0]) begin
                  pin_q <= fpc_pkg::PIN_FREE;
               end else if (tick2) begin
                  pin_q <= ~pin_q;
               end
            end
            fpc_pkg::MODE_BISTABLE: pin_q <= fpc_pkg::PIN_FREE;
         endcase
      end
   end

   assign FAULT_PIN = pin_q;

   // Hazardous timing writes; flagged even though outputs stay clean
   always_comb begin
      alarm_set = 4'h0;
      if ((second_prescaler_chg && toggling) || ((first_prescaler_chg || fsht_chg) && in_fault && !fstf_q)) begin
         alarm_set[fpc_pkg::ALARM_GROUP_SIX_7]   = 1'b1;
         alarm_set[fpc_pkg::ALARM_GROUP_TEN_21] = 1'b1;
      end
      alarm_set[fpc_pkg::ALARM_GROUP_TEN_16] = (first_prescaler_chg || rd_chg) && rt0_q;
      alarm_set[fpc_pkg::ALARM_GROUP_TEN_17] = (first_prescaler_chg || rd_chg) && rt1_q;
   end

   // Alarms are sticky until power-on reset; writes cannot clear them
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         alarm_q <= 4'h0;
      end else begin
         alarm_q <= alarm_q | alarm_set;
      end
   end

   // Interrupt status: read clears only what the read returned
   assign events[fpc_pkg::EV_ALARM] = |(alarm_set & ~alarm_q);
   assign events[fpc_pkg::EV_FAULT] = enter_fault;
   assign events[fpc_pkg::EV_FSTF]  = fstf_set;
   assign events[fpc_pkg::EV_RTEXP] = rt0_exp || rt1_exp;

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         irq_st_q <= 4'h0;
      end else if (rd_irqst) begin
         irq_st_q <= (irq_st_q & ~prdata_q[3:0]) | events;
      end else begin
         irq_st_q <= irq_st_q | events;
      end
   end

   assign IRQ = |(irq_st_q & irq_msk_q);

   // Read mux, sampled in the setup phase
   always_comb begin
      rdata = 32'h0000_0000;
      unique case (PADDR)
         fpc_pkg::OFS_PROTO:  rdata = proto_q;
         fpc_pkg::OFS_RECOV:  rdata[fpc_pkg::RD_LSB +: TW] = rd_q;
         fpc_pkg::OFS_STATUS: begin
            rdata[fpc_pkg::ST_FAULT]     = in_fault;
            rdata[fpc_pkg::ST_FSTF]      = fstf_q;
            rdata[fpc_pkg::ST_RT0]       = rt0_q;
            rdata[fpc_pkg::ST_RT1]       = rt1_q;
            rdata[fpc_pkg::ST_PIN +: 2]  = pin_q;
         end
         fpc_pkg::OFS_ALARM:  rdata[3:0] = alarm_q;
         fpc_pkg::OFS_IRQST:  rdata[3:0] = irq_st_q;
         fpc_pkg::OFS_IRQMSK: rdata[3:0] = irq_msk_q;
         default:             rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         prdata_q <= 32'h0000_0000;
         slverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q <= PWRITE ? 32'h0000_0000 : rdata;
         slverr_q <= !mapped;
      end
   end

   // Checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);

   a_bistable_pins: assert property (
      (!in_fault && mode == fpc_pkg::MODE_BISTABLE) |=> (FAULT_PIN == fpc_pkg::PIN_FREE))
      else $error("Bistable fault-free pins wrong");

   a_timesw_toggle: assert property (
      (!in_fault && mode == fpc_pkg::MODE_TIMESW && tick2)
      |=> (FAULT_PIN[0] != $past(FAULT_PIN[0])) && !FAULT_PIN[1])
      else $error("Time-switching pin did not toggle");

   a_dualrail_toggle: assert property (
      (!in_fault && mode == fpc_pkg::MODE_DUALRAIL && tick2 && (pin_q[0] != pin_q[1]))
      |=> (FAULT_PIN == ~$past(FAULT_PIN)))
      else $error("Dual-rail pins did not toggle together");

   a_flag_hold: assert property (
      (in_fault && !fstf_q && fs_cnt_q < fsht) |=> !fstf_q)
      else $error("Fault-state time flag set early");

   a_second_prescaler_alarm: assert property (
      (second_prescaler_chg && toggling) |=> alarm_q[fpc_pkg::ALARM_GROUP_SIX_7] && alarm_q[fpc_pkg::ALARM_GROUP_TEN_21])
      else $error("Second prescaler alarm missing");

   a_alarm_sticky: assert property (
      ##1 ((alarm_q & $past(alarm_q)) == $past(alarm_q)))
      else $error("Alarm cleared without reset");

   a_fault_alarm: assert property (
      ((first_prescaler_chg || fsht_chg) && in_fault && !fstf_q)
      |=> alarm_q[fpc_pkg::ALARM_GROUP_SIX_7] && alarm_q[fpc_pkg::ALARM_GROUP_TEN_21])
      else $error("Early fault-state write alarm missing");

   a_rt_alarm: assert property (
      ((first_prescaler_chg || rd_chg) && rt1_q) |=> alarm_q[fpc_pkg::ALARM_GROUP_TEN_17])
      else $error("Recovery timer write alarm missing");

   a_rt_status: assert property (
      (setup && !PWRITE && PADDR == fpc_pkg::OFS_STATUS)
      |=> (PRDATA[fpc_pkg::ST_RT0] == $past(rt0_q)) && (PRDATA[fpc_pkg::ST_RT1] == $past(rt1_q)))
      else $error("Recovery running bits misreported");

   a_pin_steady: assert property (
      (!in_fault && mode == fpc_pkg::MODE_TIMESW && !tick2 && !FAULT_PIN[1]) |=> $stable(FAULT_PIN))
      else $error("Pin changed between period ticks");

   c_fault_entry:  cover property (!in_fault ##1 in_fault);
   c_alarm_raise:  cover property ($rose(alarm_q[fpc_pkg::ALARM_GROUP_TEN_16]));
   c_dual_toggle:  cover property (mode == fpc_pkg::MODE_DUALRAIL && $changed(FAULT_PIN) && !in_fault);
   c_irq:          cover property ($rose(IRQ));
endmodule

// ### tb/fpc_safety_mon.sv
// Safety monitor model watching the two fault signalling pins
`timescale 1ns/1ps
module fpc_safety_mon (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        clr,
   input  wire logic [1:0]  fault_pin,
   output logic      [15:0] chg0,
   output logic      [15:0] chg1,
   output logic      [15:0] same
);
   logic [1:0] prev_q;

   // Counts edges per pin and cycles with equal pins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= 2'b01;
         chg0   <= 16'h0000;
         chg1   <= 16'h0000;
         same   <= 16'h0000;
      end else if (clr) begin
         prev_q <= fault_pin;
         chg0   <= 16'h0000;
         chg1   <= 16'h0000;
         same   <= 16'h0000;
      end else begin
         prev_q <= fault_pin;
         if (fault_pin[0] != prev_q[0]) chg0 <= chg0 + 16'h0001;
         if (fault_pin[1] != prev_q[1]) chg1 <= chg1 + 16'h0001;
         if (fault_pin[0] == fault_pin[1]) same <= same + 16'h0001;
      end
   end
endmodule

// ### tb/tb_fault_pin_protocol_config.sv
// Register level test of the fault pin protocol control block
`timescale 1ns/1ps
module tb_fault_pin_protocol_config;
   localparam int LIMIT = 3000;
   logic        clk_sys;
   logic        rstn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        fault_req;
   logic [1:0]  fault_pin;
   logic        irq;
   logic        mon_clr;
   logic [15:0] chg0;
   logic [15:0] chg1;
   logic [15:0] same;
   logic [31:0] rd;
   logic        err;
   int          num_errors;
   int          num_checks;
   int          cyc_cnt;

   fpc_fault_pin_ctrl DUT (
      .CLK_SYS(clk_sys), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .FAULT_REQ(fault_req), .FAULT_PIN(fault_pin), .IRQ(irq));

   fpc_safety_mon u_mon (.clk(clk_sys), .rst_n(rstn), .clr(mon_clr), .fault_pin(fault_pin),
      .chg0(chg0), .chg1(chg1), .same(same));

   always #2.5 clk_sys = ~clk_sys;

   task automatic summarize;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Bounded run; a hang ends in the report
   always @(posedge clk_sys) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == LIMIT) begin
         num_errors++;
         summarize();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic do_reset;
      rstn <= 1'b0;
      cyc(20);
      rstn <= 1'b1;
   endtask

   // One APB transfer, held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string msg);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd & m, exp, msg);
   endtask

   function automatic logic [31:0] proto(input logic [1:0] md, input logic [7:0] p1, input logic [7:0] p2,
                                         input logic [7:0] ht);
      return {4'h0, ht, p2, p1, 2'h0, md};
   endfunction

   // Clears the monitor, then lets 40 cycles of pin activity pass
   task automatic mon_win;
      cyc(4);
      mon_clr <= 1'b1;
      @(posedge clk_sys);
      mon_clr <= 1'b0;
      cyc(40);
   endtask

   initial begin
      clk_sys = 1'b0; rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0000_0000; fault_req = 1'b0; mon_clr = 1'b0;
      num_errors = 0; num_checks = 0; cyc_cnt = 0;
      do_reset();
      rdc(fpc_pkg::OFS_PROTO, 32'hffff_ffff, 32'h0000_0000, "proto reset");
      rdc(fpc_pkg::OFS_IRQMSK, 32'hffff_ffff, 32'h0000_0000, "mask reset");
      rdc(fpc_pkg::OFS_ALARM, 32'hffff_ffff, 32'h0000_0000, "alarm reset");
      rdc(fpc_pkg::OFS_STATUS, 32'h0000_003f, 32'h0000_0010, "status reset");
      apb(1'b0, 8'h18, 32'h0000_0000);
      chk({31'h0, err}, 32'h0000_0001, "unmapped error");
      chk(rd, 32'h0000_0000, "unmapped data");
      chk({31'h0, irq}, 32'h0000_0000, "irq idle");
      chk({31'h0, pready}, 32'h0000_0001, "ready high");
      $display("test reset_map done");
      // Timing first in bistable, mode in its own write
      wr(fpc_pkg::OFS_PROTO, proto(2'b00, 8'h00, 8'h01, 8'h10));
      wr(fpc_pkg::OFS_PROTO, proto(2'b10, 8'h00, 8'h01, 8'h10));
      mon_win();
      chk({31'h0, chg0 >= 16'd18 && chg0 <= 16'd22}, 32'h1, "tsw pin0 rate");
      chk({16'h0, chg1}, 32'h0, "tsw pin1 still");
      wr(fpc_pkg::OFS_PROTO, proto(2'b00, 8'h00, 8'h01, 8'h10));
      rdc(fpc_pkg::OFS_PROTO, 32'h3, 32'h0, "bistable readback 1");
      rdc(fpc_pkg::OFS_PROTO, 32'h3, 32'h0, "bistable readback 2");
      rdc(fpc_pkg::OFS_STATUS, 32'h30, 32'h10, "bistable pins");
      wr(fpc_pkg::OFS_PROTO, proto(2'b01, 8'h00, 8'h01, 8'h10));
      mon_win();
      chk({31'h0, chg0 >= 16'd18 && chg0 <= 16'd22}, 32'h1, "dual pin0 rate");
      chk({16'h0, chg1}, {16'h0, chg0}, "dual pins together");
      chk({16'h0, same}, 32'h0, "dual pins complementary");
      wr(fpc_pkg::OFS_PROTO, proto(2'b11, 8'h00, 8'h01, 8'h10));
      rdc(fpc_pkg::OFS_PROTO, 32'h3, 32'h3, "mode 11 readback");
      mon_win();
      chk({16'h0, chg0 | chg1}, 32'h0, "mode 11 static");
      rdc(fpc_pkg::OFS_ALARM, 32'hf, 32'h0, "no alarm on clean sequence");
      $display("test modes done");
      // Hazardous second prescaler write while toggling
      wr(fpc_pkg::OFS_PROTO, proto(2'b10, 8'h00, 8'h01, 8'h10));
      cyc(4);
      wr(fpc_pkg::OFS_PROTO, proto(2'b10, 8'h00, 8'h02, 8'h10));
      rdc(fpc_pkg::OFS_ALARM, 32'hf, 32'h9, "prescaler two alarm");
      chk({31'h0, irq}, 32'h0, "irq masked");
      wr(fpc_pkg::OFS_IRQMSK, 32'h0000_0001);
      cyc(1);
      chk({31'h0, irq}, 32'h1, "irq raised");
      rdc(fpc_pkg::OFS_IRQST, 32'h1, 32'h1, "irq status alarm");
      cyc(1);
      chk({31'h0, irq}, 32'h0, "irq cleared by read");
      rdc(fpc_pkg::OFS_ALARM, 32'hf, 32'h9, "alarm sticky");
      do_reset();
      rdc(fpc_pkg::OFS_ALARM, 32'hf, 32'h0, "alarm cleared by reset");
      $display("test alarm_irq done");
      // Fault state and its minimum duration
      wr(fpc_pkg::OFS_PROTO, proto(2'b00, 8'h00, 8'h01, 8'h14));
      @(posedge clk_sys);
      fault_req <= 1'b1;
      @(posedge clk_sys);
      fault_req <= 1'b0;
      cyc(3);
      chk({30'h0, fault_pin}, 32'h0, "fault pins");
      rdc(fpc_pkg::OFS_STATUS, 32'h3, 32'h1, "flag low early");
      wr(fpc_pkg::OFS_PROTO, proto(2'b00, 8'h00, 8'h01, 8'h10));
      rdc(fpc_pkg::OFS_ALARM, 32'hf, 32'h9, "early high time alarm");
      cyc(40);
      rdc(fpc_pkg::OFS_STATUS, 32'h3, 32'h3, "flag after duration");
      wr(fpc_pkg::OFS_RECOV, 32'h0000_0400);
      cyc(3);
      rdc(fpc_pkg::OFS_STATUS, 32'h31, 32'h10, "fault left");
      do_reset();
      $display("test fault_state done");
      // Recovery timers and their running bits
      wr(fpc_pkg::OFS_RECOV, 32'h0000_011e);
      rdc(fpc_pkg::OFS_STATUS, 32'hc, 32'h4, "timer0 only");
      wr(fpc_pkg::OFS_RECOV, 32'h0000_021e);
      rdc(fpc_pkg::OFS_STATUS, 32'hc, 32'hc, "both timers");
      rdc(fpc_pkg::OFS_ALARM, 32'hf, 32'h0, "same delay no alarm");
      wr(fpc_pkg::OFS_PROTO, proto(2'b00, 8'h01, 8'h00, 8'h00));
      rdc(fpc_pkg::OFS_ALARM, 32'hf, 32'h6, "timer alarms");
      cyc(100);
      rdc(fpc_pkg::OFS_STATUS, 32'hd, 32'h1, "timers expired into fault");
      rdc(fpc_pkg::OFS_IRQST, 32'ha, 32'ha, "expiry and fault events");
      $display("test recovery done");
      summarize();
   end
endmodule
